/* File: design/gpf_dev.sv */
`timescale 1ns/10ps

// Functional notes
// - four function bits, one per pin, 1=digital
// - reset clears all function bits to analog
// - pins stay disabled until function bit set
// - link runs in mode 1, polarity 0 phase 1
// - host holds serial clock low when idle
// - outgoing bits change only on rising edges within a frame
// - incoming bits sampled on falling edges
// - direction bits, 0 output (reset), 1 input
// - level bits drive outputs, show input levels
module gpf_dev
  import gpf_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // serial link
  gpf_spi_if.dev          spi,
  // shared pins
  input  wire logic [3:0] i_pin_in,
  output logic      [3:0] o_pin_out,
  output logic      [3:0] o_pin_oe,
  output logic      [3:0] o_pin_function,
  output logic      [3:0] o_pin_direction
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_DATA = 3'b100
  } gpf_dev_state_t;

  // synchronisers for everything arriving from outside
  logic       sclk_s1;
  logic       sclk_s2;
  logic       sclk_s3;
  logic       cs_s1;
  logic       cs_s2;
  logic       mosi_s1;
  logic       mosi_s2;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;

  // link state
  gpf_dev_state_t state;
  gpf_dev_state_t next_state;
  logic [3:0]     bit_cnt;
  logic [3:0]     next_bit_cnt;
  logic [7:0]     shift_in;
  logic [7:0]     next_shift_in;
  logic [7:0]     cmd;
  logic [7:0]     next_cmd;
  logic [7:0]     tx;
  logic [7:0]     next_tx;
  logic           miso_q;
  logic           next_miso_q;
  logic           miso_oe_q;
  logic           next_miso_oe_q;

  // register file
  logic [3:0] func;
  logic [3:0] next_func;
  logic [3:0] dir;
  logic [3:0] next_dir;
  logic [3:0] level;
  logic [3:0] next_level;
  logic [3:0] oe_q;
  logic [3:0] next_oe_q;

  // decoded strobes
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_act;
  logic       wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [3:0] level_view;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      pin_s1  <= 4'h0;
      pin_s2  <= 4'h0;
    end else begin
      sclk_s1 <= spi.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1   <= spi.cs_n;
      cs_s2   <= cs_s1;
      mosi_s1 <= spi.mosi;
      mosi_s2 <= mosi_s1;
      pin_s1  <= i_pin_in;
      pin_s2  <= pin_s1;
    end
  end

  // idle-low clock means the first edge in a frame is a rise
  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  assign cs_act    = ~cs_s2;

  // digital input pins show their sampled level, everything else the latch
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level_view[i] = (func[i] & dir[i]) ? pin_s2[i] : level[i];
    end
  end

  // decoded from the address byte still in the shifter, so tx loads once
  always_comb begin
    unique case ({shift_in[5:0], mosi_s2})
      ADDR_PIN_FUNC:  rd_data = {FUNC_HI_ZERO, func};
      ADDR_PIN_LEVEL: rd_data = {dir, level_view};
      default:        rd_data = 8'h00;
    endcase
  end

  // link: shift in on falls, shift out on rises
  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shift_in  = shift_in;
    next_cmd       = cmd;
    next_tx        = tx;
    next_miso_q    = miso_q;
    next_miso_oe_q = cs_act;
    wr_en          = 1'b0;
    wr_addr        = cmd[6:0];
    wr_data        = {shift_in[6:0], mosi_s2};
    if (!cs_act) begin
      // a frame cut short by the host is simply dropped
      next_state   = ST_IDLE;
      next_bit_cnt = 4'h0;
      next_miso_q  = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_state   = ST_CMD;
          next_bit_cnt = 4'h0;
          next_miso_q  = 1'b0;
        end
        ST_CMD: begin
          if (sclk_fall) begin
            next_shift_in = {shift_in[6:0], mosi_s2};
            next_bit_cnt  = bit_cnt + 4'h1;
            if (bit_cnt == LAST_CMD_BIT) begin
              next_cmd   = {shift_in[6:0], mosi_s2};
              // read data is captured once the command byte is complete
              next_tx    = rd_data;
              next_state = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            next_miso_q = tx[7];
            next_tx     = {tx[6:0], 1'b0};
          end
          if (sclk_fall) begin
            next_shift_in = {shift_in[6:0], mosi_s2};
            next_bit_cnt  = bit_cnt + 4'h1;
            if (bit_cnt == LAST_FRAME_BIT) begin
              wr_en      = cmd[CMD_WR_BIT];
              next_state = ST_CMD;
            end
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state     <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shift_in  <= 8'h00;
      cmd       <= 8'h00;
      tx        <= 8'h00;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shift_in  <= next_shift_in;
      cmd       <= next_cmd;
      tx        <= next_tx;
      miso_q    <= next_miso_q;
      miso_oe_q <= next_miso_oe_q;
    end
  end

  // register file and pin drive
  always_comb begin
    next_func  = func;
    next_dir   = dir;
    next_level = level;
    if (wr_en) begin
      unique case (wr_addr)
        ADDR_PIN_FUNC: next_func = wr_data[FUNC_LSB +: 4];
        ADDR_PIN_LEVEL: begin
          next_dir   = wr_data[DIR_LSB +: 4];
          next_level = wr_data[LEVEL_LSB +: 4];
        end
        default: ;
      endcase
    end
    // a pin drives only when made digital and set as output
    next_oe_q = next_func & ~next_dir;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      func  <= FUNC_RST;
      dir   <= DIR_RST;
      level <= LEVEL_RST;
      oe_q  <= 4'h0;
    end else begin
      func  <= next_func;
      dir   <= next_dir;
      level <= next_level;
      oe_q  <= next_oe_q;
    end
  end

  assign spi.miso_drv    = miso_q;
  assign spi.miso_oe     = miso_oe_q;
  assign o_pin_out       = level;
  assign o_pin_oe        = oe_q;
  assign o_pin_function  = func;
  assign o_pin_direction = dir;

endmodule

/* File: design/gpf_pkg.sv */
package gpf_pkg;

  // register addresses on the serial link
  localparam logic [6:0] ADDR_PIN_LEVEL = 7'h10;
  localparam logic [6:0] ADDR_PIN_FUNC  = 7'h11;

  // field positions
  localparam int DIR_LSB    = 4;
  localparam int LEVEL_LSB  = 0;
  localparam int FUNC_LSB   = 0;
  localparam int CMD_WR_BIT = 7;

  // reset values, then the zero upper function bits
  localparam logic [3:0] FUNC_RST  = 4'h0;
  localparam logic [3:0] DIR_RST   = 4'h0;
  localparam logic [3:0] LEVEL_RST = 4'h0;
  localparam logic [3:0] FUNC_HI_ZERO = 4'h0;

  // frame layout: command byte then data byte
  localparam logic [3:0] LAST_CMD_BIT   = 4'h7;
  localparam logic [3:0] LAST_FRAME_BIT = 4'hf;

  // timing of the serial clock the host makes
  localparam int CLK_NS        = 25;
  localparam int SCLK_HALF_NS  = 250;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] HALF_LOAD = 8'(SCLK_HALF_CYC - 1);

endpackage

/* File: design/gpf_spi_if.sv */
`timescale 1ns/10ps
interface gpf_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_drv;
  logic miso_oe;
  logic miso;

  // device releases the data line outside a frame; it then reads low
  assign miso = miso_oe ? miso_drv : 1'b0;

  modport dev (
    input  sclk,
    input  cs_n,
    input  mosi,
    input  miso,
    output miso_drv,
    output miso_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input  miso
  );
endinterface

/* File: design/gpf_host.sv */
`timescale 1ns/10ps
module gpf_host
  import gpf_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // command port
  input  wire logic       i_req,
  input  wire logic       i_write,
  input  wire logic [6:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic            o_busy,
  output logic            o_done,
  output logic      [7:0] o_rdata,
  // serial link
  gpf_spi_if.host         spi
);

  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_LEAD  = 5'b00010,
    H_XFER  = 5'b00100,
    H_TRAIL = 5'b01000,
    H_GAP   = 5'b10000
  } gpf_host_state_t;

  logic            miso_s1;
  logic            miso_s2;
  gpf_host_state_t state;
  gpf_host_state_t next_state;
  logic [7:0]      timer;
  logic [7:0]      next_timer;
  logic [3:0]      bit_cnt;
  logic [3:0]      next_bit_cnt;
  logic [15:0]     tx;
  logic [15:0]     next_tx;
  logic [7:0]      rx;
  logic [7:0]      next_rx;
  logic            sclk_q;
  logic            next_sclk_q;
  logic            cs_n_q;
  logic            next_cs_n_q;
  logic            mosi_q;
  logic            next_mosi_q;
  logic            busy_q;
  logic            next_busy_q;
  logic            done_q;
  logic            next_done_q;
  logic [7:0]      rdata_q;
  logic [7:0]      next_rdata_q;
  logic [7:0]      wdata_ok;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      miso_s1 <= spi.miso;
      miso_s2 <= miso_s1;
    end
  end

  // upper function bits always go out as zero
  assign wdata_ok = (i_addr == ADDR_PIN_FUNC) ? {FUNC_HI_ZERO, i_wdata[3:0]} : i_wdata;

  always_comb begin
    next_state   = state;
    next_timer   = (timer == 8'h00) ? HALF_LOAD : timer - 8'h01;
    next_bit_cnt = bit_cnt;
    next_tx      = tx;
    next_rx      = rx;
    next_sclk_q  = sclk_q;
    next_cs_n_q  = cs_n_q;
    next_mosi_q  = mosi_q;
    next_busy_q  = busy_q;
    next_done_q  = 1'b0;
    next_rdata_q = rdata_q;
    unique case (state)
      H_IDLE: begin
        next_timer  = HALF_LOAD;
        next_sclk_q = 1'b0;
        if (i_req) begin
          next_tx      = {i_write, i_addr, wdata_ok};
          next_cs_n_q  = 1'b0;
          next_busy_q  = 1'b1;
          next_bit_cnt = 4'h0;
          next_state   = H_LEAD;
        end
      end
      H_LEAD: begin
        if (timer == 8'h00) begin
          next_sclk_q = 1'b1;
          next_mosi_q = tx[15];
          next_tx     = {tx[14:0], 1'b0};
          next_state  = H_XFER;
        end
      end
      H_XFER: begin
        if (timer == 8'h00) begin
          if (sclk_q) begin
            next_sclk_q  = 1'b0;
            next_rx      = {rx[6:0], miso_s2};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == LAST_FRAME_BIT) begin
              next_state = H_TRAIL;
            end
          end else begin
            next_sclk_q = 1'b1;
            next_mosi_q = tx[15];
            next_tx     = {tx[14:0], 1'b0};
          end
        end
      end
      H_TRAIL: begin
        if (timer == 8'h00) begin
          next_cs_n_q  = 1'b1;
          next_mosi_q  = 1'b0;
          next_rdata_q = rx;
          next_done_q  = 1'b1;
          next_state   = H_GAP;
        end
      end
      H_GAP: begin
        // lets the device see chip select high between frames
        if (timer == 8'h00) begin
          next_busy_q = 1'b0;
          next_state  = H_IDLE;
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state   <= H_IDLE;
      timer   <= HALF_LOAD;
      bit_cnt <= 4'h0;
      tx      <= 16'h0000;
      rx      <= 8'h00;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      mosi_q  <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      state   <= next_state;
      timer   <= next_timer;
      bit_cnt <= next_bit_cnt;
      tx      <= next_tx;
      rx      <= next_rx;
      sclk_q  <= next_sclk_q;
      cs_n_q  <= next_cs_n_q;
      mosi_q  <= next_mosi_q;
      busy_q  <= next_busy_q;
      done_q  <= next_done_q;
      rdata_q <= next_rdata_q;
    end
  end

  assign spi.sclk = sclk_q;
  assign spi.cs_n = cs_n_q;
  assign spi.mosi = mosi_q;
  assign o_busy   = busy_q;
  assign o_done   = done_q;
  assign o_rdata  = rdata_q;

endmodule

/* File: bench/gpf_chk.sv */
`timescale 1ns/10ps
module gpf_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_drv,
  input wire logic miso_oe
);
  logic       sclk_q;
  logic [4:0] rise_cnt;
  logic [4:0] next_rise_cnt;

  // rising serial clock edges seen in the current frame
  always_comb begin
    next_rise_cnt = rise_cnt;
    if (cs_n) next_rise_cnt = 5'h00;
    else if (sclk && !sclk_q) next_rise_cnt = rise_cnt + 5'h01;
  end

  always_ff @(posedge i_clk) begin
    sclk_q   <= i_nrst ? sclk : 1'b0;
    rise_cnt <= i_nrst ? next_rise_cnt : 5'h00;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_high; sclk [*8]; endsequence
  sequence s_low; !sclk [*8]; endsequence

  property p_idle; cs_n |-> !sclk; endproperty
  property p_half; $rose(sclk) |-> s_high; endproperty
  property p_lead; $fell(cs_n) |-> s_low; endproperty
  property p_mosi; $changed(mosi) |-> $rose(sclk) || $rose(cs_n); endproperty
  // byte phase only: frame start and end may clear the shifter
  property p_miso;
    $changed(miso_drv) && !cs_n && rise_cnt != 5'h00 && !(rise_cnt == 5'h10 && !sclk)
      |-> sclk;
  endproperty
  property p_sample; $fell(sclk) |-> $stable(mosi) && $stable(miso_drv); endproperty
  property p_oe_on; $fell(cs_n) |-> ##[1:4] miso_oe; endproperty
  property p_oe_off; $rose(cs_n) |-> ##[1:4] !miso_oe; endproperty
  property p_frame; $rose(cs_n) |-> rise_cnt == 5'h10; endproperty

  a_idle: assert property (p_idle) else $error("sclk high while idle");
  a_half: assert property (p_half) else $error("sclk high phase short");
  a_lead: assert property (p_lead) else $error("sclk rose too soon");
  a_mosi: assert property (p_mosi) else $error("mosi moved off a rise");
  a_miso: assert property (p_miso) else $error("miso moved off a rise");
  a_sample: assert property (p_sample) else $error("data moved at a fall");
  a_oe_on: assert property (p_oe_on) else $error("miso not driven");
  a_oe_off: assert property (p_oe_off) else $error("miso not released");
  a_frame: assert property (p_frame) else $error("frame not 16 bits");
endmodule

/* File: bench/gpf_tb.sv */
`timescale 1ns/10ps
module gpf_tb;
  import gpf_pkg::*;
  logic        i_clk;
  logic        i_nrst;
  logic        req;
  logic        wr;
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic        busy;
  logic        done;
  logic [7:0]  rdata;
  logic [3:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic [3:0]  pin_func;
  logic [3:0]  pin_dir;
  logic [31:0] seed;
  int          miscompares;
  int          checks;
  int          m_func;
  int          m_dir;
  int          m_lvl;

  gpf_spi_if spi ();

  gpf_host i_gpf_host (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req), .i_write(wr),
    .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_rdata(rdata),
    .spi(spi));

  gpf_dev i_gpf_dev (.i_clk(i_clk), .i_nrst(i_nrst), .spi(spi), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_function(pin_func),
    .o_pin_direction(pin_dir));

  gpf_chk i_gpf_chk (.i_clk(i_clk), .i_nrst(i_nrst), .sclk(spi.sclk), .cs_n(spi.cs_n),
    .mosi(spi.mosi), .miso_drv(spi.miso_drv), .miso_oe(spi.miso_oe));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // digital input pins read the pin, all others the latch
  function logic [7:0] exp_rd(input logic [6:0] a);
    logic [3:0] gin;
    gin = 4'(m_func & m_dir);
    if (a == ADDR_PIN_FUNC) return {4'h0, 4'(m_func)};
    if (a == ADDR_PIN_LEVEL) return {4'(m_dir), (4'(m_lvl) & ~gin) | (pin_in & gin)};
    return 8'h00;
  endfunction

  task mwr(input logic [6:0] a, input logic [7:0] d);
    if (a == ADDR_PIN_FUNC) m_func = d[3:0];
    if (a == ADDR_PIN_LEVEL) begin
      m_dir = d[7:4];
      m_lvl = d[3:0];
    end
  endtask

  task pins();
    check("function", {4'h0, pin_func}, {4'h0, 4'(m_func)});
    check("direction", {4'h0, pin_dir}, {4'h0, 4'(m_dir)});
    check("level", {4'h0, pin_out}, {4'h0, 4'(m_lvl)});
    check("enable", {4'h0, pin_oe}, {4'h0, 4'(m_func & ~m_dir)});
  endtask

  // one whole frame; write frames update the model too
  task xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge i_clk); #2; n++;
    end
    req = 1'b1; wr = w; addr = a; wdata = d;
    @(posedge i_clk); #2;
    req = 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge i_clk); #2; n++;
    end
    if (done !== 1'b1) begin
      miscompares++;
      test_done();
    end else if (w) begin
      mwr(a, d);
    end else begin
      check("read", rdata, exp_rd(a));
    end
  endtask

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    i_nrst = 1'b0; req = 1'b0; wr = 1'b0; addr = 7'h00; wdata = 8'h00; pin_in = 4'h0;
    seed = 32'h82d3f12a; miscompares = 0; checks = 0; m_func = 0; m_dir = 0; m_lvl = 0;
    repeat (12) @(posedge i_clk);
    #2;
    i_nrst = 1'b1;
    pins();
    xfer(1'b0, ADDR_PIN_FUNC, 8'h00);
    xfer(1'b0, ADDR_PIN_LEVEL, 8'h00);
    $display("reset test done");
    // upper bits and unmapped places must not stick
    xfer(1'b1, ADDR_PIN_FUNC, 8'hf5);
    xfer(1'b1, 7'h12, 8'hff);
    xfer(1'b0, ADDR_PIN_FUNC, 8'h00);
    xfer(1'b0, 7'h12, 8'h00);
    pins();
    $display("refusal test done");
    for (int i = 0; i < 14; i++) begin
      pin_in = 4'(rnd());
      xfer(1'b1, rnd() % 2 ? ADDR_PIN_FUNC : ADDR_PIN_LEVEL, 8'(rnd()));
      pins();
      xfer(1'b0, ADDR_PIN_LEVEL, 8'(rnd()));
      xfer(1'b0, ADDR_PIN_FUNC, 8'(rnd()));
    end
    $display("random test done");
    test_done();
  end
endmodule
